/* File: pkg/poc_regs.svh */
// register map, field positions, reset values and timing counts
`ifndef POC_REGS_SVH
`define POC_REGS_SVH
`define POC_A_CTRL 8'h00
`define POC_A_THR 8'h04
`define POC_A_DT 8'h08
`define POC_A_RST 8'h0C
`define POC_A_HARM 8'h10
`define POC_A_STAT 8'h14
`define POC_A_EXP 8'h18
`define POC_A_REM 8'h1C
`define POC_A_RATIO 8'h20
`define POC_A_CNT_S 8'h24
`define POC_A_CNT_T 8'h28
`define POC_A_CNT_B 8'h2C
`define POC_A_REC_SEL 8'h30
`define POC_A_REC_STAMP 8'h34
`define POC_A_REC_INFO 8'h38
`define POC_A_REC_CUR 8'h3C
`define POC_A_REC_PRE 8'h40
`define POC_A_REC_REM 8'h44
`define POC_CTRL_CLR 31
`define POC_THR_RST 16'h0078
`define POC_HARM_RST 16'h0001
`define POC_DT_RST 20'h00014
`define POC_EVEN_RST 1'h1
`define POC_HYST_PCT 32'h61
`define POC_HYST_DEN 32'h64
`define POC_RATIO_MUL 32'h64
`define POC_RATIO_MAX 20'hFFFFF
`define POC_CYCLE_MS 5
`define POC_PRETRIG_MS 20
`define POC_PREFAULT_MS 200
`define POC_PRETRIG_IDX (`POC_PRETRIG_MS / `POC_CYCLE_MS)
`define POC_HIST_DEPTH (`POC_PREFAULT_MS / `POC_CYCLE_MS + 1)
`define POC_REC_NUM 12
`define POC_REC_LAST 4'hB
`define POC_CNT_MAX 16'hFFFF
`define POC_COND_NORMAL 2'h0
`define POC_COND_START 2'h1
`define POC_COND_TRIP 2'h2
`define POC_COND_BLOCKED 2'h3
`define POC_KIND_START 2'h1
`define POC_KIND_TRIP 2'h2
`define POC_KIND_BLOCK 2'h3
`endif

/* File: pkg/poc_pkg.sv */
// types shared by the overcurrent stage
package poc_pkg;
`include "poc_regs.svh"
  typedef enum logic [2:0] {
    POC_IDLE, POC_RUN, POC_TRIP, POC_REL, POC_BLK
  } poc_fsm_type;
  typedef enum logic [2:0] {
    POC_ON, POC_BLOCKED, POC_TEST, POC_TEST_BLK, POC_OFF
  } poc_mode_type;
  typedef enum logic [1:0] {
    POC_MAG_RMS, POC_MAG_TRUE_RMS_MAGNITUDE, POC_MAG_PP
  } poc_mag_type;
  typedef struct packed {
    logic [2:0][15:0] fund_rms;
    logic [2:0][15:0] true_rms_magnitude;
    logic [2:0][15:0] peak_to_peak;
    logic [15:0] harm2_ratio;
  } poc_meas_type;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } poc_apb_req_type;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } poc_apb_rsp_type;
  typedef struct packed {
    logic start;
    logic trip;
    logic blocked;
    logic [1:0] cond;
    logic [5:0] phases;
    poc_mode_type mode;
    logic [19:0] expected;
    logic [19:0] remain;
    logic [19:0] ratio;
  } poc_status_type;
  typedef struct packed {
    logic [8:0] on;
    logic [8:0] off;
    logic [31:0] stamp;
  } poc_event_type;
  typedef struct packed {
    logic [31:0] stamp;
    logic [1:0] kind;
    logic [2:0] ftype;
    logic [2:0] group;
    logic [15:0] pre;
    logic [15:0] flt;
    logic [15:0] prefault;
    logic [19:0] remain;
  } poc_rec_type;
  typedef struct packed {
    poc_fsm_type fsm;
    logic blk_s;
    logic [2:0] ph_pick;
    logic tripped;
    logic [19:0] elapsed;
    logic [19:0] rel_cnt;
    logic inverse;
    logic inrush_en;
    poc_mag_type mag_sel;
    logic ev_on_en;
    logic ev_off_en;
    poc_mode_type mode;
    logic [15:0] thr;
    logic [19:0] dt_delay;
    logic [19:0] rst_delay;
    logic [15:0] harm_lim;
    logic [15:0] cnt_s;
    logic [15:0] cnt_t;
    logic [15:0] cnt_b;
    logic [`POC_HIST_DEPTH-1:0][15:0] hist;
    logic [3:0] wr_ptr;
    logic [3:0] rec_sel;
    poc_status_type st;
    poc_event_type ev;
    poc_apb_rsp_type rsp;
  } poc_state_type;
  typedef poc_rec_type [`POC_REC_NUM-1:0] poc_recs_type;
endpackage

/* File: verilog/poc_stage.sv */
// three-phase overcurrent stage: decision, status, events and fault records
//
// What this block does
// RULE1 - blocking input sampled once at each program cycle tick, used all cycle
// RULE2 - blocking comes in on its own dedicated binary input
// RULE3 - pick-up without blocking raises start and begins delay timing
// RULE4 - pick-up with blocking raises blocked; no start, timing or trip
// RULE5 - blocking during start clears start and runs release timing
// RULE6 - source must assert blocking 5 ms before the delay expires
// RULE7 - optional second harmonic inrush block, default off, acts as blocking
// RULE8 - delay selectable definite time or inverse time, with reset timing
// RULE9 - expected time in 5 ms steps, inverse value refreshed every cycle
// RULE10 - remaining time to trip, signed, 5 ms steps
// RULE11 - ratio of highest phase current to threshold, 0.01 steps
// RULE12 - overall condition is one of normal, start, trip, blocked
// RULE13 - per-phase start and trip status for every phase combination
// RULE14 - reports behaviour mode on, blocked, test, test-blocked or off
// RULE15 - on and off events for start, trip, block and per phase
// RULE16 - configuration forwards on events, off events or both
// RULE17 - every event carries a time stamp of its status change
// RULE18 - clearable cumulative counters of start, trip and blocked
// RULE19 - twelve-entry rolling fault record, oldest overwritten
// RULE20 - records captured only on rising start, trip or blocked
// RULE21 - record holds stamp, event, type, currents, remaining time, group
// RULE22 - pick-up when any phase magnitude exceeds the common threshold
// RULE23 - pick-up releases below 97 percent of threshold
// RULE24 - magnitude selectable fundamental, true rms or peak-to-peak
// RULE25 - expired delay gives trip, held until release timing completes
// RULE26 - counters saturate, clearing acts within one program cycle
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "poc_regs.svh"
module poc_stage (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // register bus
  input wire poc_pkg::poc_apb_req_type req,
  output poc_pkg::poc_apb_rsp_type rsp,
  // program cycle and measurement
  input wire logic cycle_tick,
  input wire poc_pkg::poc_meas_type meas,
  input wire logic [19:0] inverse_time_delay,
  input wire logic [31:0] timestamp,
  input wire logic [2:0] setting_group,
  // blocking matrix
  input wire logic ext_block,
  // status and events
  output poc_pkg::poc_status_type status,
  output poc_pkg::poc_event_type events
);
  import poc_pkg::*;

  poc_state_type s;
  poc_state_type n;
  poc_recs_type recs;
  poc_recs_type next_recs;
  logic [2:0][15:0] mag;
  logic [2:0] hi;
  logic [2:0] lo;
  logic [2:0] ph_new;
  logic [15:0] mx;
  logic [31:0] quot;
  logic [19:0] ratio;
  logic inrush;
  logic mode_blk;
  logic off;
  logic blk_eff;
  logic any_new;
  logic [19:0] exp_t;
  logic acc_wr;
  logic clr_req;
  logic rec_cap;

  // per-phase magnitude select and pick-up with hysteresis
  for (genvar i = 0; i < 3; i++) begin : g_ph
    assign mag[i] = (s.mag_sel == POC_MAG_TRUE_RMS_MAGNITUDE) ? meas.true_rms_magnitude[i] :
                    (s.mag_sel == POC_MAG_PP) ? meas.peak_to_peak[i] :
                    meas.fund_rms[i]; // see RULE24
    assign hi[i] = mag[i] > s.thr; // see RULE22
    assign lo[i] = ({16'h0, mag[i]} * `POC_HYST_DEN) <
                   ({16'h0, s.thr} * `POC_HYST_PCT); // see RULE23
    assign ph_new[i] = hi[i] | (s.ph_pick[i] & ~lo[i]);
  end

  // highest phase and ratio to threshold
  always_comb begin
    mx = mag[0];
    if (mag[1] > mx) begin
      mx = mag[1];
    end
    if (mag[2] > mx) begin
      mx = mag[2];
    end
  end
  assign quot = (s.thr == 16'h0) ? 32'hFFFFFFFF :
                ({16'h0, mx} * `POC_RATIO_MUL) / {16'h0, s.thr};
  assign ratio = (quot > {12'h0, `POC_RATIO_MAX}) ? `POC_RATIO_MAX :
                 quot[19:0]; // see RULE11

  assign inrush = s.inrush_en & (meas.harm2_ratio > s.harm_lim); // see RULE7
  assign mode_blk = (s.mode == POC_BLOCKED) || (s.mode == POC_TEST_BLK);
  assign off = s.mode == POC_OFF;
  assign blk_eff = ext_block | inrush | mode_blk; // see RULE2
  assign any_new = (|ph_new) & ~off;
  assign exp_t = s.inverse ? inverse_time_delay : s.dt_delay; // see RULE8
  assign acc_wr = req.psel & req.penable & req.pwrite & s.rsp.pready;
  assign clr_req = acc_wr && (req.paddr == `POC_A_CTRL) &&
                   req.pwdata[`POC_CTRL_CLR];

  always_comb begin
    poc_rec_type rec;
    poc_rec_type nrec;
    logic [31:0] rd;
    logic hit;
    logic [8:0] v_old;
    logic [8:0] v_new;
    logic [19:0] nxt;
    rec = recs[s.rec_sel];
    nrec = '0;
    rd = 32'h0;
    hit = 1'b1;
    v_old = 9'h0;
    v_new = 9'h0;
    nxt = 20'h0;
    n = s;
    next_recs = recs;
    rec_cap = 1'b0;
    n.ev.on = 9'h0;
    n.ev.off = 9'h0;
    // register read mux
    case (req.paddr)
      `POC_A_CTRL: rd = {23'h0, s.mode, s.ev_off_en, s.ev_on_en, s.mag_sel,
                         s.inrush_en, s.inverse};
      `POC_A_THR: rd = {16'h0, s.thr};
      `POC_A_DT: rd = {12'h0, s.dt_delay};
      `POC_A_RST: rd = {12'h0, s.rst_delay};
      `POC_A_HARM: rd = {16'h0, s.harm_lim};
      `POC_A_STAT: rd = {18'h0, s.st.mode, s.st.phases, s.st.cond,
                         s.st.blocked, s.st.trip, s.st.start};
      `POC_A_EXP: rd = {12'h0, s.st.expected};
      `POC_A_REM: rd = {{12{s.st.remain[19]}}, s.st.remain};
      `POC_A_RATIO: rd = {12'h0, s.st.ratio};
      `POC_A_CNT_S: rd = {16'h0, s.cnt_s};
      `POC_A_CNT_T: rd = {16'h0, s.cnt_t};
      `POC_A_CNT_B: rd = {16'h0, s.cnt_b};
      `POC_A_REC_SEL: rd = {28'h0, s.rec_sel};
      `POC_A_REC_STAMP: rd = rec.stamp;
      `POC_A_REC_INFO: rd = {20'h0, rec.kind, rec.ftype, rec.group,
                             s.wr_ptr};
      `POC_A_REC_CUR: rd = {rec.pre, rec.flt};
      `POC_A_REC_PRE: rd = {16'h0, rec.prefault};
      `POC_A_REC_REM: rd = {{12{rec.remain[19]}}, rec.remain};
      default: hit = 1'b0;
    endcase
    n.rsp.pready = req.psel & ~req.penable;
    n.rsp.pslverr = req.psel & ~req.penable & ~hit;
    if (req.psel & ~req.penable) begin
      n.rsp.prdata = rd;
    end
    // register writes
    if (acc_wr) begin
      case (req.paddr)
        `POC_A_CTRL: begin
          n.inverse = req.pwdata[0];
          n.inrush_en = req.pwdata[1];
          n.mag_sel = (req.pwdata[3:2] > 2'h2) ? POC_MAG_RMS :
                      poc_mag_type'(req.pwdata[3:2]);
          n.ev_on_en = req.pwdata[4];
          n.ev_off_en = req.pwdata[5];
          n.mode = (req.pwdata[8:6] > 3'h4) ? POC_OFF :
                   poc_mode_type'(req.pwdata[8:6]);
          if (clr_req) begin
            n.cnt_s = 16'h0; // see RULE18
            n.cnt_t = 16'h0;
            n.cnt_b = 16'h0;
          end
        end
        `POC_A_THR: n.thr = req.pwdata[15:0];
        `POC_A_DT: n.dt_delay = req.pwdata[19:0];
        `POC_A_RST: n.rst_delay = req.pwdata[19:0];
        `POC_A_HARM: n.harm_lim = req.pwdata[15:0];
        `POC_A_REC_SEL: n.rec_sel = (req.pwdata[3:0] > `POC_REC_LAST) ?
                                    `POC_REC_LAST : req.pwdata[3:0];
        default: ;
      endcase
    end
    // program cycle evaluation
    if (cycle_tick) begin
      n.blk_s = ext_block; // see RULE1
      n.hist = {s.hist[`POC_HIST_DEPTH-2:0], mx};
      n.ph_pick = off ? 3'h0 : ph_new;
      nxt = s.elapsed + 20'h1;
      case (s.fsm)
        POC_IDLE: begin
          n.elapsed = 20'h0;
          if (any_new) begin
            n.fsm = blk_eff ? POC_BLK : POC_RUN; // see RULE3 RULE4
          end
        end
        POC_BLK: begin
          if (!any_new) begin
            n.fsm = POC_IDLE;
          end else if (!blk_eff) begin
            n.fsm = POC_RUN;
          end
        end
        POC_RUN: begin
          if (!any_new || blk_eff) begin
            n.fsm = POC_REL; // see RULE5
            n.rel_cnt = 20'h0;
          end else begin
            n.elapsed = nxt;
            if (nxt >= exp_t) begin
              n.fsm = POC_TRIP; // see RULE25
              n.tripped = 1'b1;
            end
          end
        end
        POC_TRIP: begin
          if (!any_new) begin
            n.fsm = POC_REL;
            n.rel_cnt = 20'h0;
          end
        end
        POC_REL: begin
          if (any_new && !blk_eff) begin
            n.fsm = s.tripped ? POC_TRIP : POC_RUN;
          end else if (s.rel_cnt + 20'h1 >= s.rst_delay) begin
            n.fsm = POC_IDLE; // see RULE8 RULE25
            n.tripped = 1'b0;
            n.elapsed = 20'h0;
          end else begin
            n.rel_cnt = s.rel_cnt + 20'h1;
          end
        end
        default: n.fsm = POC_IDLE;
      endcase
      if (off) begin
        n.fsm = POC_IDLE;
        n.tripped = 1'b0;
        n.elapsed = 20'h0;
      end
      // status
      n.st.start = n.fsm == POC_RUN;
      n.st.trip = n.tripped;
      n.st.blocked = any_new & blk_eff & ~n.st.start & ~n.tripped;
      if (n.st.trip) begin // see RULE12
        n.st.cond = `POC_COND_TRIP;
      end else if (n.st.start) begin
        n.st.cond = `POC_COND_START;
      end else if (n.st.blocked) begin
        n.st.cond = `POC_COND_BLOCKED;
      end else begin
        n.st.cond = `POC_COND_NORMAL;
      end
      n.st.phases = {n.ph_pick & {3{n.st.trip}},
                     n.ph_pick & {3{n.st.start}}}; // see RULE13
      n.st.mode = s.mode; // see RULE14
      n.st.expected = exp_t; // see RULE9
      n.st.remain = (n.st.start | n.st.trip) ? exp_t - n.elapsed :
                    20'h0; // see RULE10
      n.st.ratio = ratio;
      // events
      v_old = {s.st.phases, s.st.blocked, s.st.trip, s.st.start};
      v_new = {n.st.phases, n.st.blocked, n.st.trip, n.st.start};
      n.ev.on = v_new & ~v_old & {9{s.ev_on_en}}; // see RULE15 RULE16
      n.ev.off = ~v_new & v_old & {9{s.ev_off_en}};
      if (v_new != v_old) begin
        n.ev.stamp = timestamp; // see RULE17
      end
      // counters, set wins over clear
      if (n.st.start & ~s.st.start & (n.cnt_s != `POC_CNT_MAX)) begin
        n.cnt_s = n.cnt_s + 16'h1; // see RULE26
      end
      if (n.st.trip & ~s.st.trip & (n.cnt_t != `POC_CNT_MAX)) begin
        n.cnt_t = n.cnt_t + 16'h1;
      end
      if (n.st.blocked & ~s.st.blocked & (n.cnt_b != `POC_CNT_MAX)) begin
        n.cnt_b = n.cnt_b + 16'h1;
      end
      // fault record on rising edges only
      rec_cap = |(v_new[2:0] & ~v_old[2:0]); // see RULE20
      if (rec_cap) begin
        nrec.stamp = timestamp; // see RULE21
        nrec.kind = v_new[1] & ~v_old[1] ? `POC_KIND_TRIP :
                    v_new[0] & ~v_old[0] ? `POC_KIND_START :
                    `POC_KIND_BLOCK;
        nrec.ftype = n.ph_pick;
        nrec.group = setting_group;
        nrec.pre = s.hist[`POC_PRETRIG_IDX-1];
        nrec.flt = mx;
        nrec.prefault = s.hist[`POC_HIST_DEPTH-2];
        nrec.remain = n.st.remain;
        next_recs[s.wr_ptr] = nrec; // see RULE19
        n.wr_ptr = (s.wr_ptr == `POC_REC_LAST) ? 4'h0 : s.wr_ptr + 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.thr <= `POC_THR_RST;
      s.harm_lim <= `POC_HARM_RST;
      s.dt_delay <= `POC_DT_RST;
      s.ev_on_en <= `POC_EVEN_RST;
      s.ev_off_en <= `POC_EVEN_RST;
      recs <= '0;
    end else begin
      s <= n;
      recs <= next_recs;
    end
  end

  assign rsp = s.rsp;
  assign status = s.st;
  assign events = s.ev;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_block_sample: assert property ( // see RULE1
    cycle_tick |=> s.blk_s == $past(ext_block))
    else $error("blocking sample not taken at tick");
  a_block_steady: assert property ( // see RULE1
    !cycle_tick |=> $stable(s.blk_s))
    else $error("blocking sample moved between ticks");
  a_start_free: assert property ( // see RULE3
    cycle_tick && s.fsm == POC_IDLE && any_new && !blk_eff
    |=> status.start && !status.blocked)
    else $error("start missing on free pick-up");
  a_blocked_hold: assert property ( // see RULE4
    cycle_tick && s.fsm == POC_IDLE && any_new && blk_eff
    |=> status.blocked && !status.start && !status.trip)
    else $error("blocked pick-up did not show blocked");
  a_block_drops: assert property ( // see RULE5
    cycle_tick && s.fsm == POC_RUN && blk_eff
    |=> !status.start && s.fsm == POC_REL && s.rel_cnt == 20'h0)
    else $error("start not cleared by blocking");
  a_cond_match: assert property ( // see RULE12
    status.trip |-> status.cond == `POC_COND_TRIP && !status.blocked)
    else $error("condition disagrees with trip");
  a_trip_hold: assert property ( // see RULE25
    status.trip && s.fsm != POC_REL |=> status.trip)
    else $error("trip dropped before release timing");
  a_count_sat: assert property ( // see RULE26
    s.cnt_s == `POC_CNT_MAX && !clr_req |=> s.cnt_s == `POC_CNT_MAX)
    else $error("start counter wrapped");
  a_event_stamp: assert property ( // see RULE17
    events.on != 9'h0 |-> events.stamp == $past(timestamp))
    else $error("event stamp is not the change time");
  a_event_filter: assert property ( // see RULE16
    !$past(s.ev_off_en) |-> events.off == 9'h0)
    else $error("off event passed while disabled");
  a_rec_wrap: assert property ( // see RULE19
    rec_cap && s.wr_ptr == `POC_REC_LAST |=> s.wr_ptr == 4'h0)
    else $error("record pointer did not wrap");
  a_mode_off: assert property ( // see RULE14
    cycle_tick && off
    |=> s.fsm == POC_IDLE && !status.start && !status.trip)
    else $error("off mode did not force idle");
  a_phase_trip: assert property ( // see RULE13
    status.trip |-> status.phases[2:0] == 3'h0)
    else $error("phase start shown while tripped");

  c_start: cover property (status.start ##[1:1000] status.trip);
  c_blocked: cover property ($rose(status.blocked));
  c_release: cover property (status.trip ##1 !status.trip);
  c_wrap: cover property (rec_cap && s.wr_ptr == `POC_REC_LAST);
  c_inrush: cover property (cycle_tick && inrush && any_new);
endmodule
`default_nettype wire

/* File: bench/poc_far_side.sv */
// far side model: program cycle source, blocking matrix and event buffer
`timescale 1ns/1ps
`default_nettype none
module poc_far_side #(
  parameter int TICK_GAP = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench command
  input wire logic block_cmd,
  // stage side
  input wire poc_pkg::poc_event_type events,
  output logic cycle_tick,
  output logic ext_block,
  output logic [31:0] timestamp,
  // event buffer view
  output logic [31:0] tick_stamp,
  output logic [8:0][7:0] on_count,
  output logic [8:0][7:0] off_count
);
  import poc_pkg::*;
  int gap;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap <= 0;
      cycle_tick <= 1'b0;
      ext_block <= 1'b0;
      timestamp <= 32'h0;
      tick_stamp <= 32'h0;
      on_count <= '0;
      off_count <= '0;
    end else begin
      timestamp <= timestamp + 32'h1;
      gap <= (gap == TICK_GAP - 1) ? 0 : gap + 1;
      cycle_tick <= (gap == TICK_GAP - 1);
      // block moves only at a cycle start, a whole cycle ahead of use
      if (cycle_tick) begin
        ext_block <= block_cmd;
        tick_stamp <= timestamp;
      end
      for (int i = 0; i < 9; i++) begin
        on_count[i] <= on_count[i] + {7'h0, events.on[i]};
        off_count[i] <= off_count[i] + {7'h0, events.off[i]};
      end
    end
  end
endmodule
`default_nettype wire

/* File: bench/poc_stage_tb.sv */
// self-checking bench for the overcurrent stage
`timescale 1ns/1ps
`default_nettype none
`include "poc_regs.svh"
module poc_stage_tb;
  import poc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  poc_apb_req_type req = '0;
  poc_apb_rsp_type rsp;
  poc_meas_type meas = '0;
  logic [19:0] inv_dly = 20'h00006;
  logic [2:0] grp = 3'h5;
  logic block_cmd = 1'b0;
  logic cycle_tick;
  logic ext_block;
  logic [31:0] timestamp;
  logic [31:0] tick_stamp;
  logic [8:0][7:0] on_count;
  logic [8:0][7:0] off_count;
  poc_status_type status;
  poc_event_type events;
  int fail_count = 0;
  int n_checks = 0;
  int n;
  logic [31:0] q;
  logic err;
  logic [7:0] s;
  always #4 pclk = ~pclk;
  poc_stage dut (.pclk(pclk), .presetn(presetn), .req(req), .rsp(rsp),
    .cycle_tick(cycle_tick), .meas(meas), .inverse_time_delay(inv_dly),
    .timestamp(timestamp), .setting_group(grp), .ext_block(ext_block),
    .status(status), .events(events));
  poc_far_side far (.pclk(pclk), .presetn(presetn), .block_cmd(block_cmd),
    .events(events), .cycle_tick(cycle_tick), .ext_block(ext_block),
    .timestamp(timestamp), .tick_stamp(tick_stamp), .on_count(on_count),
    .off_count(off_count));
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    n_checks++;
    if (seen !== ex) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] ex, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, q, ex);
  endtask
  task ticks(input int k);
    repeat (k) begin
      do @(posedge pclk); while (cycle_tick !== 1'b1);
      @(posedge pclk);
      @(negedge pclk);
    end
  endtask
  task until_cond(input logic [1:0] c);
    n = 0;
    while (status.cond !== c && n < 12) begin
      ticks(1);
      n++;
    end
    chk("cond", status.cond, c);
    // let the release delay run out so the next pick-up starts fresh
    ticks(2);
  endtask
  task drive(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    @(posedge pclk);
    meas.fund_rms <= {c, b, a};
  endtask
  initial begin
    #300000;
    fail_count++;
    tally_and_finish;
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rchk(`POC_A_THR, 32'h78, "thr");
    rchk(`POC_A_HARM, 32'h1, "harm_lim");
    rchk(`POC_A_CTRL, 32'h30, "ctrl");
    rchk(8'h48, 32'h0, "unmapped");
    chk("slverr", err, 32'h1);
    apb(1'b1, `POC_A_THR, 32'h64);
    apb(1'b1, `POC_A_DT, 32'h4);
    apb(1'b1, `POC_A_RST, 32'h2);
    for (int p = 1; p < 8; p++) begin
      drive(p[0] ? 16'h96 : 16'h0, p[1] ? 16'h96 : 16'h0, p[2] ? 16'h96 : 16'h0);
      ticks(2);
      chk("start", status.start, 32'h1);
      chk("phases", status.phases, {29'h0, p[2:0]});
      drive(16'h0, 16'h0, 16'h0);
      until_cond(`POC_COND_NORMAL);
    end
    chk("start_on", on_count[0], 32'h7);
    chk("start_off", off_count[0], 32'h7);
    chk("a_start_on", on_count[3], 32'h4);
    apb(1'b1, `POC_A_REC_SEL, 32'h0);
    rchk(`POC_A_REC_CUR, 32'h96, "rec_cur");
    rchk(`POC_A_REC_PRE, 32'h0, "rec_pre");
    apb(1'b0, `POC_A_REC_INFO, 32'h0);
    chk("rec_info", {q[11:10], q[6:0]}, {23'h0, 2'h1, 3'h5, 4'h7});
    drive(16'h0, 16'h96, 16'h0);
    ticks(1);
    chk("ratio", status.ratio, 32'h96);
    chk("expected", status.expected, 32'h4);
    chk("remain", status.remain <= 20'h4 && status.remain != 0, 32'h1);
    chk("stamp", events.stamp - tick_stamp <= 32'h1, 32'h1);
    n = 0;
    while (status.trip !== 1'b1 && n < 10) begin
      ticks(1);
      n++;
    end
    chk("trip_ticks", n >= 2 && n <= 4, 32'h1);
    chk("cond_trip", status.cond, `POC_COND_TRIP);
    chk("trip_phases", status.phases, 32'h10);
    chk("trip_on", on_count[1], 32'h1);
    drive(16'h0, 16'h62, 16'h0);
    ticks(3);
    chk("hyst", status.trip, 32'h1);
    drive(16'h0, 16'h60, 16'h0);
    ticks(1);
    chk("trip_hold", status.trip, 32'h1);
    until_cond(`POC_COND_NORMAL);
    apb(1'b1, `POC_A_CTRL, 32'h31);
    drive(16'h0, 16'h96, 16'h0);
    ticks(1);
    chk("inv_exp", status.expected, 32'h6);
    @(posedge pclk);
    inv_dly <= 20'h00009;
    ticks(1);
    chk("inv_exp2", status.expected, 32'h9);
    drive(16'h0, 16'h0, 16'h0);
    until_cond(`POC_COND_NORMAL);
    apb(1'b1, `POC_A_CTRL, 32'h30);
    @(posedge pclk);
    block_cmd <= 1'b1;
    ticks(1);
    drive(16'h96, 16'h0, 16'h0);
    ticks(2);
    chk("blk_cond", status.cond, `POC_COND_BLOCKED);
    chk("blk_start", status.start, 32'h0);
    @(posedge pclk);
    block_cmd <= 1'b0;
    drive(16'h0, 16'h0, 16'h0);
    until_cond(`POC_COND_NORMAL);
    apb(1'b1, `POC_A_HARM, 32'h64);
    apb(1'b1, `POC_A_CTRL, 32'h32);
    @(posedge pclk);
    meas.harm2_ratio <= 16'h0200;
    drive(16'h96, 16'h0, 16'h0);
    ticks(2);
    chk("inrush", status.blocked, 32'h1);
    drive(16'h0, 16'h0, 16'h0);
    until_cond(`POC_COND_NORMAL);
    apb(1'b1, `POC_A_CTRL, 32'h30);
    rchk(`POC_A_CNT_S, 32'h9, "cnt_s");
    rchk(`POC_A_CNT_T, 32'h1, "cnt_t");
    rchk(`POC_A_CNT_B, 32'h2, "cnt_b");
    apb(1'b0, `POC_A_REC_INFO, 32'h0);
    chk("wr_ptr", q[3:0], 32'h0);
    drive(16'h96, 16'h0, 16'h0);
    ticks(1);
    chk("start5", status.start, 32'h1);
    @(posedge pclk);
    block_cmd <= 1'b1;
    ticks(3);
    chk("blk_clr", status.start, 32'h0);
    @(posedge pclk);
    block_cmd <= 1'b0;
    drive(16'h0, 16'h0, 16'h0);
    until_cond(`POC_COND_NORMAL);
    s = on_count[0];
    apb(1'b1, `POC_A_CTRL, 32'h20);
    drive(16'h96, 16'h0, 16'h0);
    ticks(2);
    chk("on_gated", on_count[0], s);
    s = off_count[0];
    drive(16'h0, 16'h0, 16'h0);
    until_cond(`POC_COND_NORMAL);
    chk("off_kept", off_count[0], s + 8'h1);
    apb(1'b1, `POC_A_CTRL, 32'h80000030);
    ticks(1);
    rchk(`POC_A_CNT_S, 32'h0, "cnt_clr");
    for (int g = 1; g < 3; g++) begin
      apb(1'b1, `POC_A_CTRL, 32'h30 | (g << 2));
      @(posedge pclk);
      meas.true_rms_magnitude[0] <= (g == 1) ? 16'h96 : 16'h0;
      meas.peak_to_peak[0] <= (g == 2) ? 16'h96 : 16'h0;
      ticks(2);
      chk("mag_start", status.start, 32'h1);
      chk("mag_ratio", status.ratio, 32'h96);
      @(posedge pclk);
      meas.true_rms_magnitude[0] <= 16'h0;
      meas.peak_to_peak[0] <= 16'h0;
      until_cond(`POC_COND_NORMAL);
    end
    for (int m = 0; m < 6; m++) begin
      apb(1'b1, `POC_A_CTRL, 32'h30 | ((m == 5 ? 7 : m) << 6));
      ticks(1);
      chk("mode", status.mode, m == 5 ? 4 : m);
    end
    tally_and_finish;
  end
endmodule
`default_nettype wire
